/* verilog/rfsr_pkg.sv */
// Purpose: Constants for receive frame status reporting.
// Assumes: Byte-wide receive stream, first byte is the destination address.
// Notes:
// Operation
// - Error vector meaningful only with the last-beat marker; any bit marks frame errored.
// - Bit 4: length field below 0x600 and received payload shorter than it.
// - Bit 3: frame longer than the configured maximum frame size.
// - Bit 2: frame, destination address through check sequence, shorter than 64 bytes.
// - Bit 1: computed frame check sequence differs from the received one.
// - Bit 0: frame ended by a control character other than terminate.
// - Whenever bit 0 is set, bit 1 is set in the same cycle.
// - Info valid strobe high exactly when the 40-bit info word is valid.
// - Info bits 38, 37, 36: unicast, multicast, broadcast destination.
// - Info bits 39, 35, 34: priority flow control, pause, other control frame.
// - Info bit 33 single VLAN tag, bit 32 stacked VLAN tags.
// - Info bits 31:16 hold frame length, destination address through check sequence.
// - Info bits 15:0 hold the payload length in bytes.
// - One pause bit per flow queue, high while that queue is paused.
package rfsr_pkg;
  localparam int ERR_W        = 6;
  localparam int INFO_W       = 40;
  localparam int LEN_W        = 16;
  localparam int FLOW_QUEUE_N = 8;

  localparam int ERR_PAYLEN    = 4;
  localparam int ERR_OVERSIZE  = 3;
  localparam int ERR_UNDERSIZE = 2;
  localparam int ERR_CRC       = 1;
  localparam int ERR_MALFORMED = 0;

  localparam int INFO_PFC     = 39;
  localparam int INFO_UCAST   = 38;
  localparam int INFO_MCAST   = 37;
  localparam int INFO_BCAST   = 36;
  localparam int INFO_PAUSE   = 35;
  localparam int INFO_CONTROL = 34;
  localparam int INFO_VLAN    = 33;
  localparam int INFO_STACKED = 32;
  localparam int INFO_FRLEN   = 16;
  localparam int INFO_PAYLEN  = 0;

  localparam logic [15:0] TYPE_VLAN      = 16'h8100;
  localparam logic [15:0] TYPE_SVLAN     = 16'h88A8;
  localparam logic [15:0] TYPE_MACCTRL   = 16'h8808;
  localparam logic [15:0] OP_PAUSE       = 16'h0001;
  localparam logic [15:0] OP_PFC         = 16'h0101;
  localparam logic [15:0] LEN_TYPE_LIMIT = 16'h0600;
  localparam logic [15:0] MIN_FRAME_LEN  = 16'h0040;
  localparam logic [15:0] HDR_LEN        = 16'h000E;
  localparam logic [15:0] TAG_LEN        = 16'h0004;
  localparam logic [15:0] FCS_LEN        = 16'h0004;
  localparam logic [15:0] LEN_MAX        = 16'hFFFF;
  localparam logic [15:0] LEN_ZERO       = 16'h0000;
  localparam logic [15:0] LEN_ONE        = 16'h0001;

  localparam logic [15:0] IDX_DST_FIRST = 16'h0000;
  localparam logic [15:0] IDX_DST_LAST  = 16'h0005;
  localparam logic [15:0] IDX_ETYPE0    = 16'h000D;
  localparam logic [15:0] IDX_OPCODE    = 16'h000F;
  localparam logic [15:0] IDX_ETYPE1    = 16'h0011;
  localparam logic [15:0] IDX_PTIME0    = 16'h0013;
  localparam logic [15:0] IDX_ETYPE2    = 16'h0015;
  localparam logic [15:0] IDX_STEP      = 16'h0002;

  localparam logic [7:0]  BYTE_ONES   = 8'hFF;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  typedef enum logic [0:0] {
    RFSR_IDLE  = 1'h0,
    RFSR_FRAME = 1'h1
  } rfsr_state_e;
endpackage

/* verilog/rfsr_crc32.sv */
// Purpose: Byte-wise frame check sequence accumulator.
// Assumes: Reflected bit order, least significant bit first.
// Notes: crcNext is combinational, includes the current byte.
`timescale 1ns/1ps
module rfsr_crc32 (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic        enable,
  input  wire logic [7:0]  dataByte,
  output      logic [31:0] crcNext
);
  import rfsr_pkg::*;

  logic [31:0] crc_q;
  logic [31:0] crcBase;

  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  assign crcBase = start ? CRC_INIT : crc_q;
  assign crcNext = crcStep(crcBase, dataByte);

  always_ff @(posedge clock) begin
    if (srst) begin
      crc_q <= CRC_INIT;
    end else if (enable) begin
      crc_q <= crcNext;
    end
  end
endmodule

/* verilog/rfsr_top.sv */
// Purpose: Receive frame error flags, frame info word and per-queue pause.
// Assumes: One byte per beat; frame includes the check sequence.
// Notes: Reports appear one cycle after the last input beat.
`timescale 1ns/1ps
module rfsr_top (
  input  wire logic                                clock,
  input  wire logic                                srst,
  input  wire logic                                inBeatValid,
  input  wire logic                                inFirst,
  input  wire logic                                inLast,
  input  wire logic [7:0]                          inByte,
  input  wire logic                                inBadTerm,
  input  wire logic [rfsr_pkg::LEN_W-1:0]          maxFrameSize,
  output      logic                                rxLastBeat_q,
  output      logic [rfsr_pkg::ERR_W-1:0]          rxFrameErrorFlags_q,
  output      logic                                rxFrameInfoValid_q,
  output      logic [rfsr_pkg::INFO_W-1:0]         rxFrameInfoWord_q,
  output      logic [rfsr_pkg::FLOW_QUEUE_N-1:0]   pauseQueue_q
);
  import rfsr_pkg::*;

  // ----------------------------------------------------------------
  // Beat acceptance and byte position
  // ----------------------------------------------------------------
  rfsr_state_e       state_q;
  logic [LEN_W-1:0]  cnt_q;
  logic [7:0]        prevByte_q;
  logic              take;
  logic              endNow;
  logic [LEN_W-1:0]  idx;
  logic [15:0]       word;

  assign take   = inBeatValid && (inFirst || state_q == RFSR_FRAME);
  assign endNow = take && inLast;
  assign idx    = inFirst ? IDX_DST_FIRST : cnt_q;
  assign word   = {prevByte_q, inByte};

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= RFSR_IDLE;
    end else begin
      case (state_q)
        RFSR_IDLE: begin
          if (take && !inLast) begin
            state_q <= RFSR_FRAME;
          end
        end
        RFSR_FRAME: begin
          if (endNow) begin
            state_q <= RFSR_IDLE;
          end
        end
        default: begin
          state_q <= RFSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_q      <= LEN_ZERO;
      prevByte_q <= 8'h00;
    end else if (take) begin
      cnt_q      <= (idx == LEN_MAX) ? LEN_MAX : idx + LEN_ONE;
      prevByte_q <= inByte;
    end
  end

  // ----------------------------------------------------------------
  // Header capture
  // ----------------------------------------------------------------
  logic        dstMcast_q;
  logic        dstAllOnes_q;
  logic [15:0] etype0_q;
  logic [15:0] etype1_q;
  logic [15:0] etype2_q;
  logic [15:0] opcode_q;
  logic [15:0] pauseTime_q [FLOW_QUEUE_N];

  always_ff @(posedge clock) begin
    if (srst) begin
      dstMcast_q   <= 1'b0;
      dstAllOnes_q <= 1'b0;
      etype0_q     <= LEN_ZERO;
      etype1_q     <= LEN_ZERO;
      etype2_q     <= LEN_ZERO;
      opcode_q     <= LEN_ZERO;
      for (int k = 0; k < FLOW_QUEUE_N; k++) begin
        pauseTime_q[k] <= LEN_ZERO;
      end
    end else if (take) begin
      if (inFirst) begin
        dstMcast_q   <= inByte[0];
        dstAllOnes_q <= (inByte == BYTE_ONES);
        etype0_q     <= LEN_ZERO;
        etype1_q     <= LEN_ZERO;
        etype2_q     <= LEN_ZERO;
        opcode_q     <= LEN_ZERO;
      end else if (idx <= IDX_DST_LAST) begin
        dstAllOnes_q <= dstAllOnes_q && (inByte == BYTE_ONES);
      end
      if (idx == IDX_ETYPE0) begin
        etype0_q <= word;
      end
      if (idx == IDX_OPCODE) begin
        opcode_q <= word;
      end
      if (idx == IDX_ETYPE1) begin
        etype1_q <= word;
      end
      if (idx == IDX_ETYPE2) begin
        etype2_q <= word;
      end
      for (int k = 0; k < FLOW_QUEUE_N; k++) begin
        if (idx == IDX_PTIME0 + IDX_STEP * LEN_W'(k)) begin
          pauseTime_q[k] <= word;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame check sequence
  // ----------------------------------------------------------------
  logic [31:0] crcNext;

  rfsr_crc32 u_crc (
    .clock    (clock),
    .srst     (srst),
    .start    (inFirst),
    .enable   (take),
    .dataByte (inByte),
    .crcNext  (crcNext)
  );

  // ----------------------------------------------------------------
  // End of frame classification
  // ----------------------------------------------------------------
  logic             isStacked;
  logic             isVlan;
  logic             isCtrl;
  logic             isPause;
  logic             isPfc;
  logic [15:0]      lenType;
  logic [LEN_W-1:0] frameLen;
  logic [LEN_W-1:0] overhead;
  logic [LEN_W-1:0] payloadLen;
  logic [ERR_W-1:0] errs;
  logic [INFO_W-1:0] info;

  assign isStacked = (etype0_q == TYPE_SVLAN) ||
                     (etype0_q == TYPE_VLAN && etype1_q == TYPE_VLAN);
  assign isVlan    = (etype0_q == TYPE_VLAN) && !isStacked;
  assign isCtrl    = (etype0_q == TYPE_MACCTRL);
  assign isPause   = isCtrl && (opcode_q == OP_PAUSE);
  assign isPfc     = isCtrl && (opcode_q == OP_PFC);
  assign lenType   = isStacked ? etype2_q : (isVlan ? etype1_q : etype0_q);
  assign frameLen  = (idx == LEN_MAX) ? LEN_MAX : idx + LEN_ONE;
  assign overhead  = HDR_LEN + FCS_LEN + (isStacked ? TAG_LEN + TAG_LEN :
                                          (isVlan ? TAG_LEN : LEN_ZERO));
  assign payloadLen = (frameLen > overhead) ? frameLen - overhead : LEN_ZERO;

  always_comb begin
    errs = '0;
    errs[ERR_PAYLEN]    = (lenType < LEN_TYPE_LIMIT) && (payloadLen < lenType);
    errs[ERR_OVERSIZE]  = frameLen > maxFrameSize;
    errs[ERR_UNDERSIZE] = frameLen < MIN_FRAME_LEN;
    errs[ERR_MALFORMED] = inBadTerm;
    errs[ERR_CRC]       = (crcNext != CRC_RESIDUE) || inBadTerm;
  end

  always_comb begin
    info = '0;
    info[INFO_PFC]     = isPfc;
    info[INFO_PAUSE]   = isPause;
    info[INFO_CONTROL] = isCtrl && !isPause && !isPfc;
    info[INFO_UCAST]   = !dstMcast_q;
    info[INFO_MCAST]   = dstMcast_q && !dstAllOnes_q;
    info[INFO_BCAST]   = dstMcast_q && dstAllOnes_q;
    info[INFO_VLAN]    = isVlan;
    info[INFO_STACKED] = isStacked;
    info[INFO_FRLEN +: LEN_W]  = frameLen;
    info[INFO_PAYLEN +: LEN_W] = payloadLen;
  end

  // ----------------------------------------------------------------
  // Client outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      rxLastBeat_q        <= 1'b0;
      rxFrameErrorFlags_q <= '0;
      rxFrameInfoValid_q  <= 1'b0;
      rxFrameInfoWord_q   <= '0;
    end else begin
      rxLastBeat_q        <= endNow;
      rxFrameErrorFlags_q <= endNow ? errs : '0;
      rxFrameInfoValid_q  <= endNow;
      rxFrameInfoWord_q   <= endNow ? info : '0;
    end
  end

  // ----------------------------------------------------------------
  // Per-queue pause timers
  // ----------------------------------------------------------------
  logic goodCtrlEnd;
  assign goodCtrlEnd = endNow && (errs == '0);

  for (genvar g = 0; g < FLOW_QUEUE_N; g++) begin : gQueue
    logic [15:0] timer_q;
    logic        load;
    logic [15:0] loadVal;
    assign load    = goodCtrlEnd && (isPause || (isPfc && etype1_q[g]));
    assign loadVal = isPause ? etype1_q : pauseTime_q[g];
    always_ff @(posedge clock) begin
      if (srst) begin
        timer_q         <= LEN_ZERO;
        pauseQueue_q[g] <= 1'b0;
      end else if (load) begin
        timer_q         <= loadVal;
        pauseQueue_q[g] <= loadVal != LEN_ZERO;
      end else begin
        timer_q         <= (timer_q != LEN_ZERO) ? timer_q - LEN_ONE : LEN_ZERO;
        pauseQueue_q[g] <= timer_q > LEN_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_flags_last_only: assert property (rxFrameErrorFlags_q != '0 |-> rxLastBeat_q)
    else $error("error flags outside last beat");
  chk_valid_tracks_end: assert property (endNow |=> rxFrameInfoValid_q && rxLastBeat_q)
    else $error("info valid missing after frame end");
  chk_valid_needs_end: assert property (rxFrameInfoValid_q |-> $past(endNow))
    else $error("info valid without frame end");
  chk_malformed_crc: assert property (rxFrameErrorFlags_q[ERR_MALFORMED]
      |-> rxFrameErrorFlags_q[ERR_CRC])
    else $error("malformed without crc flag");
  chk_bad_term_flag: assert property (endNow && inBadTerm
      |=> rxFrameErrorFlags_q[ERR_MALFORMED])
    else $error("bad termination not flagged");
  chk_undersize_flag: assert property (rxFrameInfoValid_q
      && rxFrameInfoWord_q[INFO_FRLEN +: LEN_W] < MIN_FRAME_LEN
      |-> rxFrameErrorFlags_q[ERR_UNDERSIZE])
    else $error("short frame not flagged");
  chk_oversize_flag: assert property (rxFrameInfoValid_q
      |-> rxFrameErrorFlags_q[ERR_OVERSIZE]
          == (rxFrameInfoWord_q[INFO_FRLEN +: LEN_W] > $past(maxFrameSize)))
    else $error("oversize flag wrong");
  chk_dest_onehot: assert property (rxFrameInfoValid_q
      |-> $onehot(rxFrameInfoWord_q[INFO_BCAST +: 3]))
    else $error("destination class not one-hot");
  chk_tag_excl: assert property (!(rxFrameInfoWord_q[INFO_VLAN]
      && rxFrameInfoWord_q[INFO_STACKED]))
    else $error("single and stacked tag both set");
  chk_payload_le_len: assert property (rxFrameInfoValid_q
      |-> rxFrameInfoWord_q[INFO_PAYLEN +: LEN_W] < rxFrameInfoWord_q[INFO_FRLEN +: LEN_W]
          || rxFrameInfoWord_q[INFO_FRLEN +: LEN_W] == LEN_ZERO)
    else $error("payload not shorter than frame");
  chk_pause_all: assert property (goodCtrlEnd && isPause && etype1_q > LEN_ONE
      |=> pauseQueue_q == '1 ##1 pauseQueue_q == '1)
    else $error("pause frame did not pause queues");

  cov_good_frame:  cover property (rxFrameInfoValid_q && rxFrameErrorFlags_q == '0);
  cov_crc_error:   cover property (rxFrameErrorFlags_q[ERR_CRC]);
  cov_pfc_frame:   cover property (rxFrameInfoValid_q && rxFrameInfoWord_q[INFO_PFC]);
  cov_queue_pause: cover property ($rose(pauseQueue_q[0]));
endmodule

/* verif/rfsr_client_model.sv */
// Purpose: Client logic that takes frame reports off the receive side.
// Assumes: Reports are one-cycle pulses marked by the valid strobe.
// Notes: Keeps the last report seen and counts frames marked errored.
`timescale 1ns/1ps
module rfsr_client_model (
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic                         rxLastBeat_q,
  input  wire logic [rfsr_pkg::ERR_W-1:0]   rxFrameErrorFlags_q,
  input  wire logic                         rxFrameInfoValid_q,
  input  wire logic [rfsr_pkg::INFO_W-1:0]  rxFrameInfoWord_q,
  output      logic [rfsr_pkg::INFO_W-1:0]  seenWord_q,
  output      logic [rfsr_pkg::ERR_W-1:0]   seenFlags_q,
  output      logic [7:0]                   errFrames_q
);
  import rfsr_pkg::*;

  always_ff @(posedge clock) begin
    if (srst) begin
      seenWord_q <= '0;
    end else if (rxFrameInfoValid_q) begin
      seenWord_q <= rxFrameInfoWord_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      seenFlags_q <= '0;
      errFrames_q <= 8'h00;
    end else if (rxLastBeat_q) begin
      seenFlags_q <= rxFrameErrorFlags_q;
      if (rxFrameErrorFlags_q != '0) begin
        errFrames_q <= errFrames_q + 8'h01;
      end
    end
  end
endmodule

/* verif/tb_rx_mac_frame_status_report.sv */
// Purpose: Self-checking bench for receive frame reports and pause levels.
// Assumes: One byte per beat, reports one cycle after the last beat.
// Notes: One pause quantum is one clock cycle.
`timescale 1ns/1ps
module tb_rx_mac_frame_status_report;
  import rfsr_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock;
  logic        srst;
  logic        inBeatValid;
  logic        inFirst;
  logic        inLast;
  logic [7:0]  inByte;
  logic        inBadTerm;
  logic [15:0] maxFrameSize;
  logic        rxLastBeat_q;
  logic [5:0]  rxFrameErrorFlags_q;
  logic        rxFrameInfoValid_q;
  logic [39:0] rxFrameInfoWord_q;
  logic [7:0]  pauseQueue_q;
  logic [39:0] clientWord;
  logic [5:0]  clientFlags;
  logic [7:0]  clientErrs;
  logic [7:0]  frm [0:127];
  logic [5:0]  gotFlags;
  logic [39:0] gotWord;
  logic [7:0]  gotQ;
  int          pauseLen;
  int          mismatches;
  int          totalChecks;

  rfsr_top u_rfsr_top (.clock(clock), .srst(srst), .inBeatValid(inBeatValid),
    .inFirst(inFirst), .inLast(inLast), .inByte(inByte), .inBadTerm(inBadTerm),
    .maxFrameSize(maxFrameSize), .rxLastBeat_q(rxLastBeat_q),
    .rxFrameErrorFlags_q(rxFrameErrorFlags_q), .rxFrameInfoValid_q(rxFrameInfoValid_q),
    .rxFrameInfoWord_q(rxFrameInfoWord_q), .pauseQueue_q(pauseQueue_q));

  rfsr_client_model u_rfsr_client_model (.clock(clock), .srst(srst),
    .rxLastBeat_q(rxLastBeat_q), .rxFrameErrorFlags_q(rxFrameErrorFlags_q),
    .rxFrameInfoValid_q(rxFrameInfoValid_q), .rxFrameInfoWord_q(rxFrameInfoWord_q),
    .seenWord_q(clientWord), .seenFlags_q(clientFlags), .errFrames_q(clientErrs));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic check_flags(input logic [5:0] got, input logic [5:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [39:0] got, input logic [39:0] exp,
                            input logic [39:0] m);
    totalChecks++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_queue(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Frame building and sending
  // ----------------------------------------
  task automatic mk(input logic [7:0] da0, input logic [15:0] et, input int n);
    for (int i = 0; i < n; i++) frm[i] = 8'(i);
    for (int i = 0; i < 6; i++) frm[i] = (da0 == 8'hFF) ? 8'hFF : ((i == 0) ? da0 : 8'h22);
    {frm[12], frm[13]} = et;
  endtask

  task automatic send(input int n, input logic bt, input logic badCrc);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n - 4; i++) begin
      c = c ^ {24'h000000, frm[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    c = ~c ^ (badCrc ? 32'h00000001 : 32'h00000000);
    {frm[n-1], frm[n-2], frm[n-3], frm[n-4]} = c;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      inBeatValid <= 1'b1;
      inFirst <= (i == 0);
      inLast <= (i == n - 1);
      inByte <= frm[i];
      inBadTerm <= bt && (i == n - 1);
    end
    // Last beat still pending: no report yet
    @(negedge clock);
    check_queue({6'h00, rxLastBeat_q, rxFrameInfoValid_q}, 8'h00);
    @(posedge clock);
    inBeatValid <= 1'b0;
    inLast <= 1'b0;
    inBadTerm <= 1'b0;
    // Report stands in the cycle after the last beat
    @(negedge clock);
    check_queue({6'h00, rxLastBeat_q, rxFrameInfoValid_q}, 8'h03);
    gotFlags = rxFrameErrorFlags_q;
    gotWord = rxFrameInfoWord_q;
    gotQ = pauseQueue_q;
    @(negedge clock);
    check_queue({6'h00, rxLastBeat_q, rxFrameInfoValid_q}, 8'h00);
    check_flags(rxFrameErrorFlags_q, 6'h00);
    check_word(rxFrameInfoWord_q, 40'h0000000000, 40'hFFFFFFFFFF);
    pauseLen = (gotQ != 8'h00) ? 1 : 0;
    while (pauseQueue_q !== 8'h00 && pauseLen < 40) begin
      pauseLen++;
      @(negedge clock);
    end
    if (pauseLen >= 40) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic expect_frame(input logic [5:0] ef, input logic [39:0] ew,
                              input logic [7:0] eq, input logic [7:0] el);
    check_flags(gotFlags, ef);
    check_word(gotWord, ew, 40'hFFFFFFFFFF);
    check_queue(gotQ, eq);
    check_queue(8'(pauseLen), el);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_classes();
    mk(8'h02, 16'h0800, 64);
    send(64, 1'b0, 1'b0);
    expect_frame(6'h00, {8'h40, 16'h0040, 16'h002E}, 8'h00, 8'h00);
    check_word(clientWord, {8'h40, 16'h0040, 16'h002E}, 40'hFFFFFFFFFF);
    mk(8'h01, 16'h0800, 60);
    send(60, 1'b0, 1'b0);
    expect_frame(6'h04, {8'h20, 16'h003C, 16'h002A}, 8'h00, 8'h00);
    mk(8'h02, 16'h8100, 68);
    {frm[16], frm[17]} = 16'h0800;
    send(68, 1'b0, 1'b0);
    expect_frame(6'h00, {8'h42, 16'h0044, 16'h002E}, 8'h00, 8'h00);
    mk(8'h02, 16'h88A8, 72);
    {frm[16], frm[17], frm[20], frm[21]} = 32'h81000800;
    send(72, 1'b0, 1'b0);
    expect_frame(6'h00, {8'h41, 16'h0048, 16'h002E}, 8'h00, 8'h00);
    $display("test classes done");
  endtask

  task automatic t_errors();
    mk(8'hFF, 16'h0800, 64);
    send(64, 1'b0, 1'b1);
    expect_frame(6'h02, {8'h10, 16'h0040, 16'h002E}, 8'h00, 8'h00);
    check_queue(clientErrs, 8'h02);
    mk(8'h02, 16'h0800, 64);
    send(64, 1'b1, 1'b0);
    check_flags(gotFlags, 6'h03);
    check_flags(clientFlags, 6'h03);
    @(posedge clock);
    maxFrameSize <= 16'h0040;
    mk(8'h02, 16'h0800, 65);
    send(65, 1'b0, 1'b0);
    expect_frame(6'h08, {8'h40, 16'h0041, 16'h002F}, 8'h00, 8'h00);
    mk(8'h02, 16'h0800, 64);
    send(64, 1'b0, 1'b0);
    check_flags(gotFlags, 6'h00);
    @(posedge clock);
    maxFrameSize <= 16'h05EE;
    mk(8'h02, 16'h0064, 64);
    send(64, 1'b0, 1'b0);
    check_flags(gotFlags, 6'h10);
    mk(8'h02, 16'h002E, 64);
    send(64, 1'b0, 1'b0);
    check_flags(gotFlags, 6'h00);
    $display("test errors done");
  endtask

  task automatic t_pause();
    mk(8'h01, 16'h8808, 64);
    {frm[14], frm[15], frm[16], frm[17]} = 32'h00010005;
    send(64, 1'b0, 1'b0);
    expect_frame(6'h00, {8'h28, 16'h0040, 16'h002E}, 8'hFF, 8'h05);
    send(64, 1'b0, 1'b1);
    check_queue(gotQ, 8'h00);
    {frm[14], frm[15]} = 16'h0002;
    send(64, 1'b0, 1'b0);
    expect_frame(6'h00, {8'h24, 16'h0040, 16'h002E}, 8'h00, 8'h00);
    {frm[14], frm[15], frm[16], frm[17]} = 32'h01010005;
    {frm[18], frm[19], frm[22], frm[23]} = 32'h00030003;
    send(64, 1'b0, 1'b0);
    expect_frame(6'h00, {8'hA0, 16'h0040, 16'h002E}, 8'h05, 8'h03);
    $display("test pause done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    inBeatValid = 1'b0;
    inFirst = 1'b0;
    inLast = 1'b0;
    inByte = 8'h00;
    inBadTerm = 1'b0;
    maxFrameSize = 16'h05EE;
    mismatches = 0;
    totalChecks = 0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    t_classes();
    t_errors();
    t_pause();
    report_and_stop();
  end

  initial begin
    #3000000;
    mismatches++;
    report_and_stop();
  end
endmodule
